// *** testbench/display_ram_write_addressing_tb_top.sv ***
/*
  Testbench: controller end and display RAM end joined by the link.
  Assumes the package and interface are compiled first.
*/
`default_nettype none

module display_ram_write_addressing_tb_top
  import ldw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    ldw_mode_type mode;
    logic bank;
    logic [2:0] unit;
    logic [5:0] col;
    logic [7:0] data;
    logic [5:0] ptr;
    logic [2:0] sub;
  } ldw_row_type;

  logic clk, rst_n, req_valid, req_ready_ff, req_err_ff, ptr_ok_ff;
  logic bank_ff, last_err;
  logic stored_ff, dropped_ff, last_stored, last_dropped;
  ldw_req_type req_kind;
  logic [2:0] req_unit, pins, sub_cnt_ff;
  logic [7:0] req_arg;
  logic [5:0] rd_col, ptr_ff;
  logic [3:0] rd_data_ff;
  ldw_mode_type mode_ff;
  logic [3:0] mem [60];
  ldw_row_type rows [9];
  int err_count, checks;

  ldw_if u_ldw_if (.clk(clk), .rst_n(rst_n));
  ldw_host u_ldw_host (.link(u_ldw_if), .req_valid(req_valid),
    .req_kind(req_kind), .req_unit(req_unit), .req_arg(req_arg),
    .req_ready_ff(req_ready_ff), .req_err_ff(req_err_ff),
    .ptr_ok_ff(ptr_ok_ff));
  ldw_device u_ldw_device (.link(u_ldw_if), .hw_subaddr_bit_lo(pins[0]),
    .hw_subaddr_bit_mid(pins[1]), .hw_subaddr_bit_hi(pins[2]),
    .rd_col(rd_col), .rd_data_ff(rd_data_ff), .ptr_ff(ptr_ff),
    .sub_cnt_ff(sub_cnt_ff), .mode_ff(mode_ff), .bank_ff(bank_ff),
    .stored_ff(stored_ff), .dropped_ff(dropped_ff));
  ldw_link_properties u_ldw_link_properties (.clk(clk), .rst_n(rst_n),
    .cmd_valid(u_ldw_if.cmd_valid), .cmd_kind(u_ldw_if.cmd_kind),
    .cmd_arg(u_ldw_if.cmd_arg));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until taken, then lets the link commands land
  task automatic req(ldw_req_type k, logic [2:0] u, logic [7:0] a);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind = k;
    req_unit = u;
    req_arg = a;
    n = 0;
    while (req_ready_ff !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      print_verdict();
    end
    @(negedge clk);
    last_err = req_err_ff;
    req_valid = 1'b0;
    // The device acts one edge after the host puts the command out
    @(negedge clk);
    last_stored = stored_ff;
    last_dropped = dropped_ff;
    repeat (3) @(negedge clk);
  endtask

  // Expected RAM: bit 7 first, b bits per column, bank only in 1 and 2 bit
  task automatic model(ldw_row_type r);
    int b, c, rw;
    b = int'(r.mode) + 1;
    if (r.unit != pins) return;
    for (int i = 0; i < 8; i++) begin
      c = r.col + i / b;
      rw = i % b + ((r.bank && b < 3) ? 2 : 0);
      if (c < 60) mem[c][rw] = r.data[7 - i];
    end
  endtask

  task automatic check_mem();
    for (int c = 0; c < 60; c++) begin
      @(negedge clk);
      rd_col = 6'(c);
      @(negedge clk);
      chk("ram column", {4'h0, mem[c]}, {4'h0, rd_data_ff});
    end
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    req_valid = 1'b0;
    req_kind = LDW_REQ_DATA;
    req_unit = 3'h0;
    req_arg = 8'h00;
    rd_col = 6'h00;
    pins = 3'h5;
    err_count = 0;
    checks = 0;
    last_err = 1'b0;
    last_stored = 1'b0;
    last_dropped = 1'b0;
    foreach (mem[c]) mem[c] = 4'h0;
    rows = '{
      '{LDW_STATIC, 1'b0, 3'h5, 6'h00, 8'hA5, 6'h08, 3'h5},
      '{LDW_STATIC, 1'b1, 3'h5, 6'h08, 8'h3C, 6'h10, 3'h5},
      '{LDW_MUX2, 1'b0, 3'h5, 6'h10, 8'hC9, 6'h14, 3'h5},
      '{LDW_MUX2, 1'b1, 3'h5, 6'h14, 8'h96, 6'h18, 3'h5},
      '{LDW_MUX4, 1'b0, 3'h5, 6'h20, 8'hFF, 6'h22, 3'h5},
      '{LDW_MUX3, 1'b0, 3'h5, 6'h1E, 8'h00, 6'h21, 3'h5},
      '{LDW_STATIC, 1'b0, 3'h3, 6'h28, 8'hFF, 6'h30, 3'h3},
      '{LDW_MUX4, 1'b0, 3'h5, 6'h3A, 8'h5A, 6'h00, 3'h6},
      '{LDW_STATIC, 1'b0, 3'h5, 6'h38, 8'h81, 6'h04, 3'h6}};
    do_reset();
    foreach (rows[i]) begin
      req(LDW_REQ_MODE, 3'h0, {6'h00, rows[i].mode});
      req(LDW_REQ_BANK, 3'h0, {7'h00, rows[i].bank});
      req(LDW_REQ_SELECT, rows[i].unit, {2'h0, rows[i].col});
      chk("unit counter", {5'h0, rows[i].unit}, {5'h0, sub_cnt_ff});
      req(LDW_REQ_DATA, 3'h0, rows[i].data);
      model(rows[i]);
      chk("data pointer", {2'h0, rows[i].ptr}, {2'h0, ptr_ff});
      chk("wrapped unit", {5'h0, rows[i].sub}, {5'h0, sub_cnt_ff});
      chk("drive mode", {6'h00, rows[i].mode}, {6'h00, mode_ff});
      chk("stored", {7'h00, rows[i].unit == pins}, {7'h00, last_stored});
      chk("dropped", {7'h00, rows[i].unit != pins},
        {7'h00, last_dropped});
      check_mem();
      $display("row %0d done", i);
    end
    // Columns past the end of the RAM read as zero
    @(negedge clk);
    rd_col = 6'h3C;
    @(negedge clk);
    chk("read past end", 8'h00, {4'h0, rd_data_ff});
    // Second reset mid-run with nonzero pointer, unit counter, pointer valid and RAM
    do_reset();
    foreach (mem[c]) mem[c] = 4'h0;
    chk("pointer", 8'h00, {2'h0, ptr_ff});
    chk("unit counter", 8'h00, {5'h0, sub_cnt_ff});
    chk("bank", 8'h00, {7'h00, bank_ff});
    chk("drive mode", 8'h00, {6'h00, mode_ff});
    chk("pointer valid", 8'h00, {7'h00, ptr_ok_ff});
    check_mem();
    $display("reset test done");
    // Data with no pointer loaded, then after an abort, is refused
    req(LDW_REQ_DATA, 3'h0, 8'hFF);
    chk("refused data", 8'h01, {7'h00, last_err});
    chk("no store", 8'h00, {6'h00, last_stored, last_dropped});
    req(LDW_REQ_SELECT, 3'h5, 8'h00);
    req(LDW_REQ_ABORT, 3'h0, 8'h00);
    req(LDW_REQ_DATA, 3'h0, 8'hFF);
    chk("data after abort", 8'h01, {7'h00, last_err});
    chk("no store", 8'h00, {6'h00, last_stored, last_dropped});
    check_mem();
    $display("refusal test done");
    print_verdict();
  end
endmodule

`default_nettype wire

// *** testbench/ldw_link_properties.sv ***
/*
  Concurrent checks on the link between controller and display RAM end.
  Assumes it sees the link signals as plain inputs in the clk domain.
*/
`default_nettype none

module ldw_link_properties
  import ldw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link signals
  input wire logic cmd_valid,
  input wire ldw_cmd_type cmd_kind,
  input wire logic [7:0] cmd_arg
);
  logic ptr_seen_ff;
  logic reload_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Cleared by a pick, set by the pointer load that must follow it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_ff <= 1'b0;
    end else if (cmd_valid && cmd_kind == LDW_CMD_PICK) begin
      reload_ff <= 1'b0;
    end else if (cmd_valid && cmd_kind == LDW_CMD_PTR) begin
      reload_ff <= 1'b1;
    end
  end

  // Data is only legal once some pointer load has gone out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_seen_ff <= 1'b0;
    end else if (cmd_valid && cmd_kind == LDW_CMD_PTR) begin
      ptr_seen_ff <= 1'b1;
    end
  end

  pick_then_ptr_a: assert property (
    cmd_valid && cmd_kind == LDW_CMD_PICK |=>
    cmd_valid && cmd_kind == LDW_CMD_PTR)
    else $error("pick not followed by pointer load");
  ptr_after_pick_a: assert property (
    cmd_valid && cmd_kind == LDW_CMD_PTR |->
    $past(cmd_valid) && $past(cmd_kind) == LDW_CMD_PICK)
    else $error("pointer load without a preceding pick");
  data_needs_ptr_a: assert property (
    cmd_valid && cmd_kind == LDW_CMD_DATA |-> ptr_seen_ff)
    else $error("data sent before any pointer load");
  link_quiet_a: assert property (
    !cmd_valid |-> cmd_kind == LDW_CMD_NONE && cmd_arg == 8'h00)
    else $error("idle link carries a command");
  pick_unit_arg_a: assert property (
    cmd_valid && cmd_kind == LDW_CMD_PICK |-> cmd_arg[7:3] == 5'h00)
    else $error("unit pick carries stray bits");
  data_after_reload_a: assert property (
    cmd_valid && cmd_kind == LDW_CMD_DATA |-> reload_ff)
    else $error("data sent between pick and pointer load");
endmodule

`default_nettype wire

// *** verilog/ldw_device.sv ***
/*
  Display RAM end: 60 x 4 display RAM with the write path, data pointer,
  subaddress counter and input bank choice, plus a registered read port.
  Assumes commands arrive one per cycle on the link in the clk domain and
  that the subaddress pins are asynchronous board levels.
*/
`default_nettype none

module ldw_device
  import ldw_pkg::*;
(
  // Link from the controller
  ldw_if.dev link,
  // Subaddress pins
  input wire logic hw_subaddr_bit_lo,
  input wire logic hw_subaddr_bit_mid,
  input wire logic hw_subaddr_bit_hi,
  // Read port
  input wire logic [5:0] rd_col,
  output logic [3:0] rd_data_ff,
  // Status
  output logic [5:0] ptr_ff,
  output logic [2:0] sub_cnt_ff,
  output ldw_mode_type mode_ff,
  output logic bank_ff,
  output logic stored_ff,
  output logic dropped_ff
);

  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic [3:0] ram_ff [LDW_COLS];
  logic [3:0] nxt_col [LDW_COLS];
  logic [LDW_COLS-1:0] col_hit;
  logic [6:0] inc;
  logic [6:0] sum;
  logic [5:0] nxt_ptr;
  logic [2:0] nxt_sub;
  logic data_cmd;
  logic match;

  // Pins are board levels; synchronise them through two flops anyway
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      pin_meta_ff <= LDW_SUB_RST;
      pin_sync_ff <= LDW_SUB_RST;
    end else begin
      pin_meta_ff <= {hw_subaddr_bit_hi, hw_subaddr_bit_mid,
                      hw_subaddr_bit_lo};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign data_cmd = link.cmd_valid && (link.cmd_kind == LDW_CMD_DATA);
  assign match = (sub_cnt_ff == pin_sync_ff);

  always_comb begin
    case (mode_ff)
      LDW_STATIC: inc = LDW_INC_STATIC;
      LDW_MUX2: inc = LDW_INC_MUX2;
      LDW_MUX3: inc = LDW_INC_MUX3;
      LDW_MUX4: inc = LDW_INC_MUX4;
      default: inc = LDW_INC_STATIC;
    endcase
  end

  // Place the byte into the columns it covers, starting at the pointer.
  // Columns past 59 belong to the next cascaded unit and are not touched.
  always_comb begin
    int k;
    int r;
    k = 0;
    r = 0;
    for (int j = 0; j < LDW_COLS; j++) begin
      nxt_col[j] = ram_ff[j];
      col_hit[j] = 1'b0;
      k = j - int'(ptr_ff);
      if (k >= 0 && k < int'(inc)) begin
        col_hit[j] = 1'b1;
        case (mode_ff)
          LDW_STATIC: begin
            r = bank_ff ? LDW_ROW_ALT : LDW_ROW_MAIN;
            nxt_col[j][r] = link.cmd_arg[7-k];
          end
          LDW_MUX2: begin
            r = bank_ff ? LDW_ROW_ALT : LDW_ROW_MAIN;
            nxt_col[j][r] = link.cmd_arg[7-2*k];
            nxt_col[j][r+1] = link.cmd_arg[6-2*k];
          end
          LDW_MUX3: begin
            nxt_col[j][0] = link.cmd_arg[7-3*k];
            nxt_col[j][1] = link.cmd_arg[6-3*k];
            // Only eight bits: third column keeps its row 2 bit
            if (k < 2) begin
              nxt_col[j][2] = link.cmd_arg[5-3*k];
            end
          end
          LDW_MUX4: begin
            for (int q = 0; q < LDW_ROWS; q++) begin
              nxt_col[j][q] = link.cmd_arg[7-4*k-q];
            end
          end
          default: begin
            nxt_col[j] = ram_ff[j];
          end
        endcase
      end
    end
  end

  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      for (int j = 0; j < LDW_COLS; j++) begin
        ram_ff[j] <= 4'h0;
      end
    end else if (data_cmd && match) begin
      for (int j = 0; j < LDW_COLS; j++) begin
        if (col_hit[j]) begin
          ram_ff[j] <= nxt_col[j];
        end
      end
    end
  end

  // Pointer advance with wrap; overflow moves to the next unit
  assign sum = {1'b0, ptr_ff} + inc;

  always_comb begin
    nxt_ptr = sum[5:0];
    nxt_sub = sub_cnt_ff;
    if (sum >= LDW_COLS_W) begin
      nxt_ptr = 6'(sum - LDW_COLS_W);
      nxt_sub = 3'(sub_cnt_ff + 3'h1);
    end
  end

  // Advance happens whether or not the byte was stored
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      ptr_ff <= LDW_PTR_RST;
    end else if (link.cmd_valid && link.cmd_kind == LDW_CMD_PTR) begin
      // Out of range addresses fall back to column 0
      if (link.cmd_arg[5:0] > LDW_LAST_COL) begin
        ptr_ff <= LDW_PTR_RST;
      end else begin
        ptr_ff <= link.cmd_arg[5:0];
      end
    end else if (data_cmd) begin
      ptr_ff <= nxt_ptr;
    end
  end

  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      sub_cnt_ff <= LDW_SUB_RST;
    end else if (link.cmd_valid && link.cmd_kind == LDW_CMD_PICK) begin
      sub_cnt_ff <= link.cmd_arg[2:0];
    end else if (data_cmd) begin
      sub_cnt_ff <= nxt_sub;
    end
  end

  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      mode_ff <= LDW_MODE_RST;
    end else if (link.cmd_valid && link.cmd_kind == LDW_CMD_MODE) begin
      mode_ff <= ldw_mode_type'(link.cmd_arg[1:0]);
    end
  end

  // Bank choice only matters in static and 1:2 modes
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      bank_ff <= LDW_BANK_RST;
    end else if (link.cmd_valid && link.cmd_kind == LDW_CMD_BANK) begin
      bank_ff <= link.cmd_arg[0];
    end
  end

  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      stored_ff <= 1'b0;
      dropped_ff <= 1'b0;
    end else begin
      stored_ff <= data_cmd && match;
      dropped_ff <= data_cmd && !match;
    end
  end

  // Columns above 59 read as zero
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      rd_data_ff <= 4'h0;
    end else if (rd_col > LDW_LAST_COL) begin
      rd_data_ff <= 4'h0;
    end else begin
      rd_data_ff <= ram_ff[rd_col];
    end
  end

endmodule

`default_nettype wire

// *** verilog/ldw_host.sv ***
/*
  Controller end: turns user requests into link commands. A select
  request sends unit-pick then pointer load; data is refused while the
  pointer is not known to be valid.
  Assumes the user holds a request until it is taken with ready high.
*/
`default_nettype none

module ldw_host
  import ldw_pkg::*;
(
  // Link to the display RAM end
  ldw_if.host link,
  // User requests
  input wire logic req_valid,
  input wire ldw_req_type req_kind,
  input wire logic [2:0] req_unit,
  input wire logic [7:0] req_arg,
  output logic req_ready_ff,
  output logic req_err_ff,
  output logic ptr_ok_ff
);

  typedef enum logic {
    LDW_ST_IDLE,
    LDW_ST_PTR
  } ldw_state_type;

  ldw_state_type state_ff;
  logic cmd_valid_ff;
  ldw_cmd_type cmd_kind_ff;
  logic [7:0] cmd_arg_ff;
  logic [7:0] addr_ff;
  logic take;

  assign link.cmd_valid = cmd_valid_ff;
  assign link.cmd_kind = cmd_kind_ff;
  assign link.cmd_arg = cmd_arg_ff;
  assign take = req_valid && req_ready_ff && (state_ff == LDW_ST_IDLE);

  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      state_ff <= LDW_ST_IDLE;
      req_ready_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      case (state_ff)
        LDW_ST_IDLE: begin
          req_ready_ff <= 1'b1;
          if (take && req_kind == LDW_REQ_SELECT) begin
            state_ff <= LDW_ST_PTR;
            req_ready_ff <= 1'b0;
            addr_ff <= req_arg;
          end
        end
        LDW_ST_PTR: begin
          state_ff <= LDW_ST_IDLE;
          req_ready_ff <= 1'b1;
        end
        default: begin
          state_ff <= LDW_ST_IDLE;
        end
      endcase
    end
  end

  // Every pick is followed at once by a pointer load
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      cmd_valid_ff <= 1'b0;
      cmd_kind_ff <= LDW_CMD_NONE;
      cmd_arg_ff <= 8'h00;
    end else begin
      cmd_valid_ff <= 1'b0;
      cmd_kind_ff <= LDW_CMD_NONE;
      cmd_arg_ff <= 8'h00;
      if (state_ff == LDW_ST_PTR) begin
        cmd_valid_ff <= 1'b1;
        cmd_kind_ff <= LDW_CMD_PTR;
        cmd_arg_ff <= addr_ff;
      end else if (take) begin
        case (req_kind)
          LDW_REQ_SELECT: begin
            cmd_valid_ff <= 1'b1;
            cmd_kind_ff <= LDW_CMD_PICK;
            cmd_arg_ff <= {5'h00, req_unit};
          end
          LDW_REQ_DATA: begin
            cmd_valid_ff <= ptr_ok_ff;
            cmd_kind_ff <= ptr_ok_ff ? LDW_CMD_DATA : LDW_CMD_NONE;
            cmd_arg_ff <= ptr_ok_ff ? req_arg : 8'h00;
          end
          LDW_REQ_MODE: begin
            cmd_valid_ff <= 1'b1;
            cmd_kind_ff <= LDW_CMD_MODE;
            cmd_arg_ff <= req_arg;
          end
          LDW_REQ_BANK: begin
            cmd_valid_ff <= 1'b1;
            cmd_kind_ff <= LDW_CMD_BANK;
            cmd_arg_ff <= req_arg;
          end
          default: begin
            cmd_valid_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // An aborted transfer leaves the remote pointer unknown
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      ptr_ok_ff <= 1'b0;
      req_err_ff <= 1'b0;
    end else begin
      req_err_ff <= take && req_kind == LDW_REQ_DATA && !ptr_ok_ff;
      if (state_ff == LDW_ST_PTR) begin
        ptr_ok_ff <= 1'b1;
      end else if (take && req_kind == LDW_REQ_SELECT) begin
        ptr_ok_ff <= 1'b0;
      end else if (take && req_kind == LDW_REQ_ABORT) begin
        ptr_ok_ff <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// *** verilog/ldw_if.sv ***
/*
  Link between the controller end and the display RAM end.
  Assumes one shared clock; the controller drives all signals.
*/
`default_nettype none

interface ldw_if
  import ldw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n
);
  logic cmd_valid;
  ldw_cmd_type cmd_kind;
  logic [7:0] cmd_arg;

  modport host (input clk, input rst_n,
                output cmd_valid, output cmd_kind, output cmd_arg);
  modport dev (input clk, input rst_n,
               input cmd_valid, input cmd_kind, input cmd_arg);
endinterface

`default_nettype wire

// *** verilog/ldw_pkg.sv ***
/*
  Shared constants and types for the display RAM write addressing link:
  column count, reset values, drive modes and link command kinds.
  Assumes both ends are compiled against this package and share one clock.
*/
`default_nettype none

package ldw_pkg;

  // Display RAM geometry
  localparam int LDW_COLS = 60;
  localparam int LDW_ROWS = 4;
  localparam logic [6:0] LDW_COLS_W = 7'h3C;
  localparam logic [5:0] LDW_LAST_COL = 6'h3B;

  // Values after reset
  localparam logic [5:0] LDW_PTR_RST = 6'h00;
  localparam logic [2:0] LDW_SUB_RST = 3'h0;
  localparam logic LDW_BANK_RST = 1'b0;

  // Pointer advance per byte for each drive mode
  localparam logic [6:0] LDW_INC_STATIC = 7'h08;
  localparam logic [6:0] LDW_INC_MUX2 = 7'h04;
  localparam logic [6:0] LDW_INC_MUX3 = 7'h03;
  localparam logic [6:0] LDW_INC_MUX4 = 7'h02;

  // Row of the main and alternate input bank
  localparam int LDW_ROW_MAIN = 0;
  localparam int LDW_ROW_ALT = 2;

  typedef enum logic [1:0] {
    LDW_STATIC,
    LDW_MUX2,
    LDW_MUX3,
    LDW_MUX4
  } ldw_mode_type;

  localparam ldw_mode_type LDW_MODE_RST = LDW_STATIC;

  // Commands that travel over the link, one per valid cycle
  typedef enum logic [2:0] {
    LDW_CMD_NONE,
    LDW_CMD_DATA,
    LDW_CMD_PTR,
    LDW_CMD_PICK,
    LDW_CMD_MODE,
    LDW_CMD_BANK
  } ldw_cmd_type;

  // Requests made to the controller end by its user
  typedef enum logic [2:0] {
    LDW_REQ_SELECT,
    LDW_REQ_DATA,
    LDW_REQ_MODE,
    LDW_REQ_BANK,
    LDW_REQ_ABORT
  } ldw_req_type;

endpackage

`default_nettype wire
